// *** core/irqrc_regs.v ***
// irq routing and fast ir placement configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "irqrc_defs.vh"
// Notes on behaviour
// - serial irq select and pin irq/mode registers answer only in configuration state with their index loaded.
// - second input irq and fast ir base registers answer only in configuration state with their index loaded.
// - upper nibble of serial irq select routes port one, lower nibble routes port two.
// - every irq line that no field selects is left undriven.
// - each port's irq is driven only when its modem output-two gate is 1, then with the irq level.
// - first external irq input goes to the irq number in bits 3:0 of the pin irq/mode register.
// - bit 4 of the pin irq/mode register picks the normal infrared path at 0, the third receive input at 1.
// - bit 5 of the pin irq/mode register ignores writes and reads zero.
// - bit 7 of the pin irq/mode register enables serial irq and clock run, and resets to 1.
// - second external irq input goes to bits 3:0 of its register, whose bits 7:4 read zero.
// - fast ir base register supplies address bits 10:3 of the engine base.
// - fast ir decode is off while base bits 10:8 are all zero.
// - a fast ir access is claimed when address bits 15:11 are zero and 10:3 match the base.
// - on power-on reset the pin irq/mode register loads 0x80 and the others load 0x00.
module irqrc_regs #(
	parameter IRQ_LINES = 16
) (
	input  wire                 clock_i,
	input  wire                 arst_n_i,
	input  wire                 config_state_i,
	input  wire [7:0]           configuration_index_i,
	input  wire                 cfg_wr_i,
	input  wire                 cfg_rd_i,
	input  wire [7:0]           cfg_wdata_i,
	output reg  [7:0]           cfg_rdata_o,
	output wire                 cfg_hit_o,
	input  wire [15:0]          io_addr_i,
	output wire                 fast_ir_engine_sel_o,
	output wire [2:0]           fast_ir_engine_reg_o,
	input  wire                 uart1_irq_i,
	input  wire                 uart2_irq_i,
	input  wire                 uart1_modem_output_two_gate_i,
	input  wire                 uart2_modem_output_two_gate_i,
	input  wire                 first_external_irq_input_i,
	input  wire                 second_external_irq_input_i,
	input  wire                 normal_infrared_path_i,
	input  wire                 third_infrared_receive_input_i,
	output wire                 ir_receive_data_o,
	output wire                 ir_receive_source_select_o,
	output wire                 serial_irq_clock_run_enable_o,
	output wire [IRQ_LINES-1:0] irq_o,
	output wire [IRQ_LINES-1:0] irq_oe_o
);

	////////////////////////////////////////////////////////////////////
	// register storage

	reg  [7:0] serial_port_irq_select_reg;
	reg  [7:0] input_pin_irq_and_mode_reg;
	reg  [7:0] second_input_irq_select_reg;
	reg  [7:0] fast_ir_base_address_reg;

	// index decode, shared by reads and writes
	function idx_hit;
		input [7:0] idx;
		input [7:0] value;
		begin
			idx_hit = (idx == value);
		end
	endfunction

	wire sel_serial = config_state_i &
		idx_hit(configuration_index_i, `IRQRC_IDX_SERIAL_IRQ);
	wire sel_pin    = config_state_i &
		idx_hit(configuration_index_i, `IRQRC_IDX_PIN_MODE);
	wire sel_second = config_state_i &
		idx_hit(configuration_index_i, `IRQRC_IDX_SECOND_IRQ);
	wire sel_base   = config_state_i &
		idx_hit(configuration_index_i, `IRQRC_IDX_FIR_BASE);

	assign cfg_hit_o = sel_serial | sel_pin | sel_second | sel_base;

	// writes; masked bits keep their reset value so reserved bits stay zero
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			serial_port_irq_select_reg  <= `IRQRC_RST_SERIAL_IRQ;
			input_pin_irq_and_mode_reg  <= `IRQRC_RST_PIN_MODE;
			second_input_irq_select_reg <= `IRQRC_RST_SECOND_IRQ;
			fast_ir_base_address_reg    <= `IRQRC_RST_FIR_BASE;
		end else if (cfg_wr_i) begin
			if (sel_serial) begin
				serial_port_irq_select_reg <=
					cfg_wdata_i & `IRQRC_WMASK_SERIAL_IRQ;
			end
			if (sel_pin) begin
				input_pin_irq_and_mode_reg <=
					cfg_wdata_i & `IRQRC_WMASK_PIN_MODE;
			end
			if (sel_second) begin
				second_input_irq_select_reg <=
					cfg_wdata_i & `IRQRC_WMASK_SECOND_IRQ;
			end
			if (sel_base) begin
				fast_ir_base_address_reg <=
					cfg_wdata_i & `IRQRC_WMASK_FIR_BASE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// read data, registered so the host sees it the cycle after the strobe

	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_rdata_o <= 8'h00;
		end else if (cfg_rd_i) begin
			if (sel_serial) begin
				cfg_rdata_o <= serial_port_irq_select_reg;
			end else if (sel_pin) begin
				cfg_rdata_o <= input_pin_irq_and_mode_reg;
			end else if (sel_second) begin
				cfg_rdata_o <= second_input_irq_select_reg;
			end else if (sel_base) begin
				cfg_rdata_o <= fast_ir_base_address_reg;
			end else begin
				cfg_rdata_o <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode bits

	assign ir_receive_source_select_o =
		input_pin_irq_and_mode_reg[`IRQRC_RX_SRC_BIT];
	assign ir_receive_data_o = ir_receive_source_select_o ?
		third_infrared_receive_input_i : normal_infrared_path_i;
	assign serial_irq_clock_run_enable_o =
		input_pin_irq_and_mode_reg[`IRQRC_SIRQ_EN_BIT];

	////////////////////////////////////////////////////////////////////
	// fast ir engine address decode

	wire [7:0] fir_base = fast_ir_base_address_reg;
	wire       fir_enabled =
		|fir_base[`IRQRC_FIR_HIGH3_HI:`IRQRC_FIR_HIGH3_LO];
	wire       upper_zero =
		~|io_addr_i[`IRQRC_FIR_UPPER_HI:`IRQRC_FIR_UPPER_LO];
	wire       base_match =
		(io_addr_i[`IRQRC_FIR_BASE_HI:`IRQRC_FIR_BASE_LO] == fir_base);

	// low three address bits pick the register and are left out of the match
	assign fast_ir_engine_sel_o = fir_enabled & upper_zero & base_match;
	assign fast_ir_engine_reg_o = io_addr_i[2:0];

	////////////////////////////////////////////////////////////////////
	// irq routing; external pins pass two flops before use

	reg  [1:0] ext1_sync;
	reg  [1:0] ext2_sync;

	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ext1_sync <= 2'b00;
			ext2_sync <= 2'b00;
		end else begin
			ext1_sync <= {ext1_sync[0], first_external_irq_input_i};
			ext2_sync <= {ext2_sync[0], second_external_irq_input_i};
		end
	end

	wire [3:0] sp1_num =
		serial_port_irq_select_reg[`IRQRC_SP1_IRQ_HI:`IRQRC_SP1_IRQ_LO];
	wire [3:0] sp2_num =
		serial_port_irq_select_reg[`IRQRC_SP2_IRQ_HI:`IRQRC_SP2_IRQ_LO];
	wire [3:0] in1_num =
		input_pin_irq_and_mode_reg[`IRQRC_PIN_IRQ_HI:`IRQRC_PIN_IRQ_LO];
	wire [3:0] in2_num =
		second_input_irq_select_reg[`IRQRC_PIN_IRQ_HI:`IRQRC_PIN_IRQ_LO];

	// a port drives only when its output-two gate is set
	wire sp1_drive = uart1_modem_output_two_gate_i;
	wire sp2_drive = uart2_modem_output_two_gate_i;

	// line 0 stands for no irq, so it never drives
	genvar n;
	generate
		for (n = 0; n < IRQ_LINES; n = n + 1) begin : g_line
			wire hit1 = (n != 0) && (sp1_num == n) && sp1_drive;
			wire hit2 = (n != 0) && (sp2_num == n) && sp2_drive;
			wire hit3 = (n != 0) && (in1_num == n);
			wire hit4 = (n != 0) && (in2_num == n);
			// shared numbers are software's fault; the lowest source wins
			assign irq_oe_o[n] = hit1 | hit2 | hit3 | hit4;
			assign irq_o[n] = hit1 ? uart1_irq_i :
				hit2 ? uart2_irq_i :
				hit3 ? ext1_sync[1] :
				hit4 ? ext2_sync[1] : 1'b0;
		end
	endgenerate

endmodule // irqrc_regs
`default_nettype wire

// *** common/irqrc_defs.vh ***
// register offsets, field positions, reset values and masks of the irq routing bank
`ifndef IRQRC_DEFS_VH
`define IRQRC_DEFS_VH

// configuration index values of the four registers
`define IRQRC_IDX_SERIAL_IRQ   8'h28
`define IRQRC_IDX_PIN_MODE     8'h29
`define IRQRC_IDX_SECOND_IRQ   8'h2A
`define IRQRC_IDX_FIR_BASE     8'h2B

// power-on reset values
`define IRQRC_RST_SERIAL_IRQ   8'h00
`define IRQRC_RST_PIN_MODE     8'h80
`define IRQRC_RST_SECOND_IRQ   8'h00
`define IRQRC_RST_FIR_BASE     8'h00

// writable bits of each register
`define IRQRC_WMASK_SERIAL_IRQ 8'hFF
`define IRQRC_WMASK_PIN_MODE   8'hDF
`define IRQRC_WMASK_SECOND_IRQ 8'h0F
`define IRQRC_WMASK_FIR_BASE   8'hFF

// field positions
`define IRQRC_SP1_IRQ_HI       7
`define IRQRC_SP1_IRQ_LO       4
`define IRQRC_SP2_IRQ_HI       3
`define IRQRC_SP2_IRQ_LO       0
`define IRQRC_PIN_IRQ_HI       3
`define IRQRC_PIN_IRQ_LO       0
`define IRQRC_RX_SRC_BIT       4
`define IRQRC_SIRQ_EN_BIT      7

// fast ir address decode
`define IRQRC_FIR_UPPER_HI     15
`define IRQRC_FIR_UPPER_LO     11
`define IRQRC_FIR_BASE_HI      10
`define IRQRC_FIR_BASE_LO      3
`define IRQRC_FIR_HIGH3_HI     7
`define IRQRC_FIR_HIGH3_LO     5

`endif

// *** test/irqrc_regs_asserts.sv ***
// checker for the irq routing register bank
`timescale 1ns/1ps
`default_nettype none
module irqrc_regs_asserts (
	input wire logic        clock_i,
	input wire logic        arst_n_i,
	input wire logic        config_state_i,
	input wire logic [7:0]  configuration_index_i,
	input wire logic        cfg_wr_i,
	input wire logic        cfg_rd_i,
	input wire logic [7:0]  cfg_wdata_i,
	input wire logic [7:0]  cfg_rdata_o,
	input wire logic        cfg_hit_o,
	input wire logic [15:0] io_addr_i,
	input wire logic        fast_ir_engine_sel_o,
	input wire logic        serial_irq_clock_run_enable_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	// strobes that land on one register
	sequence s_rd(idx);
		cfg_rd_i && cfg_hit_o && configuration_index_i == idx;
	endsequence
	sequence s_wr(idx);
		cfg_wr_i && cfg_hit_o && configuration_index_i == idx;
	endsequence
	chk_hit_decode: assert property (
		cfg_hit_o == (config_state_i &&
		configuration_index_i inside {[8'h28:8'h2b]}))
		else $error("hit decode wrong");
	chk_miss_reads_zero: assert property (
		cfg_rd_i && !cfg_hit_o |=> cfg_rdata_o == 8'h00)
		else $error("refused read not zero");
	// read data must not wander between strobes
	chk_rdata_holds: assert property (!cfg_rd_i |=> $stable(cfg_rdata_o))
		else $error("read data moved");
	chk_bit5_zero: assert property (s_rd(8'h29) |=> !cfg_rdata_o[5])
		else $error("reserved bit reads one");
	chk_upper_nibble: assert property (
		s_rd(8'h2a) |=> cfg_rdata_o[7:4] == 4'h0)
		else $error("upper nibble not zero");
	chk_sirq_write: assert property (
		s_wr(8'h29) |=> serial_irq_clock_run_enable_o == $past(cfg_wdata_i[7]))
		else $error("serial irq enable not updated");
	chk_base_back: assert property (
		s_wr(8'h2b) ##2 s_rd(8'h2b) |=> cfg_rdata_o == $past(cfg_wdata_i, 3))
		else $error("base readback wrong");
	chk_upper_addr: assert property (
		fast_ir_engine_sel_o |-> io_addr_i[15:11] == 5'h00)
		else $error("claim with high address bits");
	chk_low_window: assert property (
		io_addr_i[10:8] == 3'h0 |-> !fast_ir_engine_sel_o)
		else $error("claim below 100h");
endmodule // irqrc_regs_asserts
bind irqrc_regs irqrc_regs_asserts irqrc_regs_asserts_inst (.clock_i,
	.arst_n_i, .config_state_i, .configuration_index_i, .cfg_wr_i,
	.cfg_rd_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_hit_o, .io_addr_i,
	.fast_ir_engine_sel_o, .serial_irq_clock_run_enable_o);
`default_nettype wire

// *** test/irqrc_host_model.sv ***
// host side model issuing configuration cycles
`timescale 1ns/1ps
`default_nettype none
module irqrc_host_model (
	input  wire logic       clock_i,
	input  wire logic [7:0] cfg_rdata_i,
	output var logic        config_state_o,
	output var logic [7:0]  index_o,
	output var logic        wr_o,
	output var logic        rd_o,
	output var logic [7:0]  wdata_o
);
	initial {config_state_o, index_o, wr_o, rd_o, wdata_o} = '0;
	// one strobe cycle; data flips after so a stale value never matches
	task automatic acc(input logic c, w, input logic [7:0] i, d,
		output logic [7:0] q);
		@(posedge clock_i);
		#1;
		config_state_o = c;
		index_o = i;
		wr_o = w;
		rd_o = !w;
		wdata_o = d;
		@(posedge clock_i);
		#1;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = ~d;
		q = cfg_rdata_i;
	endtask
endmodule // irqrc_host_model
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the irq routing register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock_i, arst_n_i, cs, wr, rd, u1, u2, g1, g2, p1, p2, nrm, thr;
	logic hit, sel, rxd, rxs, sen;
	logic [7:0] idx, wd, rdat, q;
	logic [2:0] rsel;
	logic [15:0] addr, irq, oe;
	int miscompares = 0;
	int check_count = 0;
	// rows: index, write data, expected readback
	logic [23:0] rows [4] = '{24'h28_a5a5, 24'h29_ffdf, 24'h2a_f303,
		24'h2b_2020};
	logic [15:0] fa [6] = '{16'h0100, 16'h0107, 16'h0108, 16'h0900,
		16'h00f8, 16'h07f8};
	logic fe [6] = '{1, 1, 0, 0, 0, 1};
	irqrc_regs irqrc_regs_inst (.clock_i, .arst_n_i, .config_state_i(cs),
		.configuration_index_i(idx), .cfg_wr_i(wr), .cfg_rd_i(rd),
		.cfg_wdata_i(wd), .cfg_rdata_o(rdat), .cfg_hit_o(hit),
		.io_addr_i(addr), .fast_ir_engine_sel_o(sel),
		.fast_ir_engine_reg_o(rsel), .uart1_irq_i(u1), .uart2_irq_i(u2),
		.uart1_modem_output_two_gate_i(g1),
		.uart2_modem_output_two_gate_i(g2),
		.first_external_irq_input_i(p1), .second_external_irq_input_i(p2),
		.normal_infrared_path_i(nrm), .third_infrared_receive_input_i(thr),
		.ir_receive_data_o(rxd), .ir_receive_source_select_o(rxs),
		.serial_irq_clock_run_enable_o(sen), .irq_o(irq), .irq_oe_o(oe));
	irqrc_host_model irqrc_host_model_inst (.clock_i, .cfg_rdata_i(rdat),
		.config_state_o(cs), .index_o(idx), .wr_o(wr), .rd_o(rd),
		.wdata_o(wd));
	task automatic chk(input logic [15:0] got, exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrc(input logic [7:0] i, d);
		irqrc_host_model_inst.acc(1'b1, 1'b1, i, d, q);
	endtask
	task automatic rdc(input logic [7:0] i, e);
		irqrc_host_model_inst.acc(1'b1, 1'b0, i, 8'h00, q);
		chk(q, e);
	endtask
	task automatic conclude();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		clock_i = 0;
		forever #5 clock_i = ~clock_i;
	end
	// the whole run needs under 600 ns
	initial begin
		#30000;
		miscompares++;
		conclude();
	end
	initial begin
		arst_n_i = 0;
		addr = 16'h0000;
		{u1, u2, g1, g2, p1, p2, nrm, thr} = '0;
		repeat (10) @(posedge clock_i);
		#1 arst_n_i = 1;
		chk(sen, 1);
		for (int n = 0; n < 4; n++)
			rdc(8'h28 + n, n == 1 ? 8'h80 : 8'h00);
		// distinct irq numbers only, sharing is not allowed
		foreach (rows[n]) begin
			wrc(rows[n][23:16], rows[n][15:8]);
			rdc(rows[n][23:16], rows[n][7:0]);
		end
		thr = 1;
		#1 chk({rxs, rxd}, 2'b11);
		irqrc_host_model_inst.acc(1'b0, 1'b1, 8'h28, 8'h00, q);
		rdc(8'h28, 8'ha5);
		rdc(8'h2c, 8'h00);
		{g1, u1, u2} = 3'b111;
		#1 chk(oe, 16'h8408);
		chk(irq[10], 1);
		g2 = 1;
		#1 chk(irq & oe, 16'h0420);
		u1 = 0;
		#1 chk(irq & oe, 16'h0020);
		{p1, p2} = 2'b11;
		repeat (3) @(posedge clock_i);
		#1 chk(irq & oe, 16'h8028);
		wrc(8'h29, 8'h10);
		chk({sen, rxs}, 2'b01);
		chk(oe, 16'h0428);
		foreach (fa[n]) begin
			if (n == 4)
				wrc(8'h2b, 8'h1f);
			if (n == 5)
				wrc(8'h2b, 8'hff);
			addr = fa[n];
			#1 chk({rsel, sel}, {fa[n][2:0], fe[n]});
		end
		// second reset in mid-run
		arst_n_i = 0;
		#1 chk({sen, rdat}, 9'h100);
		repeat (3) @(posedge clock_i);
		#1 arst_n_i = 1;
		rdc(8'h2b, 8'h00);
		conclude();
	end
endmodule // tb_top
`default_nettype wire
